// File: bench/mpz_enc_model.sv
`timescale 1ns/10ps
module mpz_enc_model (
  input wire i_clk_sys,
  input wire i_step,
  input wire i_rev,
  input wire i_index,
  output reg o_enc_a,
  output reg o_enc_b,
  output reg o_enc_z
);
  reg [1:0] ph_r = 2'h0;
  always @(posedge i_clk_sys) begin
    if (i_step) ph_r <= i_rev ? ph_r - 2'h1 : ph_r + 2'h1;
  end
  // forward: a leads b, 00 10 11 01
  always @* begin
    o_enc_a = ph_r[1] ^ ph_r[0];
    o_enc_b = ph_r[1];
    o_enc_z = i_index;
  end
endmodule

// File: bench/mpz_top_props.sv
`timescale 1ns/10ps
module mpz_top_props (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_run,
  input wire i_enc_a,
  input wire i_enc_b,
  input wire i_enc_z,
  input wire o_wb_ack,
  input wire o_pos_mode,
  input wire o_multi_pos,
  input wire o_ramp_set1,
  input wire [15:0] o_max_freq,
  input wire [3:0] o_speed_sel,
  input wire [31:0] o_index_bias
);
  // ----
  // checks
  // ----
  reg z_seen_r;
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) z_seen_r <= 1'b0;
    else if (i_enc_z) z_seen_r <= 1'b1;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  sequence s_new_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack && !$past(i_wb_cyc && i_wb_stb);
  endsequence
  sequence s_enc_quiet;
    ($stable(i_enc_a) && $stable(i_enc_b) && $stable(i_enc_z)) [*8];
  endsequence
  chk_ack_latency: assert property (s_new_req |=> !o_wb_ack ##1 o_wb_ack)
    else $error("ack not two edges after request");
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_maxf_range: assert property (
    o_max_freq >= 16'h0001 && o_max_freq <= 16'h03E8)
    else $error("max frequency out of range");
  chk_sel_zero: assert property (
    o_multi_pos |-> o_speed_sel == 4'h0)
    else $error("speed select not cleared");
  chk_multi_hold: assert property (o_multi_pos |-> o_pos_mode)
    else $error("multi position outside hold");
  chk_ramp_idle: assert property (
    !o_pos_mode [*3] |-> !o_ramp_set1)
    else $error("ramp set one outside position mode");
  chk_bias_steady: assert property (
    s_enc_quiet |-> $stable(o_index_bias))
    else $error("bias moved with encoder quiet");
  chk_bias_none: assert property (
    !z_seen_r |-> o_index_bias == 32'h0000270F)
    else $error("bias not 9999 before index");
  chk_run_drop: assert property (!i_run [*6] |-> !o_pos_mode)
    else $error("position mode without run");
endmodule
bind mpz_top mpz_top_props i_props (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_run(i_run), .i_enc_a(i_enc_a),
  .i_enc_b(i_enc_b), .i_enc_z(i_enc_z), .o_wb_ack(o_wb_ack),
  .o_pos_mode(o_pos_mode), .o_multi_pos(o_multi_pos),
  .o_ramp_set1(o_ramp_set1), .o_max_freq(o_max_freq),
  .o_speed_sel(o_speed_sel), .o_index_bias(o_index_bias));

// File: bench/multi_position_zero_servo_test.sv
`timescale 1ns/10ps
`include "mpz_defs.vh"
module multi_position_zero_servo_test;
  reg i_clk_sys, i_resetn, cyc, we, step, rev, idx, run;
  reg [7:0] adr, di;
  reg [31:0] wdat;
  reg [15:0] ofreq, lf;
  wire [31:0] rdat, pref, perr, bias;
  wire ack, pmode, mpos, ramp, ea, eb, ez;
  wire [15:0] maxf;
  wire [3:0] ssel;
  reg [31:0] exp_q[$];
  reg signed [31:0] tgt [0:15];
  reg signed [31:0] rv, pv;
  integer n_errors, n_compared, cyc_cnt, k;
  mpz_top i_mpz_top (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_di(di), .i_enc_a(ea), .i_enc_b(eb), .i_enc_z(ez),
    .i_run(run), .i_out_freq(ofreq), .o_pos_mode(pmode),
    .o_multi_pos(mpos), .o_ramp_set1(ramp), .o_max_freq(maxf),
    .o_speed_sel(ssel), .o_position_reference(pref), .o_pos_err(perr),
    .o_index_bias(bias));
  mpz_enc_model i_mpz_enc_model (.i_clk_sys(i_clk_sys), .i_step(step),
    .i_rev(rev), .i_index(idx), .o_enc_a(ea), .o_enc_b(eb), .o_enc_z(ez));
  // ----
  // helpers
  // ----
  function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge i_clk_sys);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge i_clk_sys);
      while (ack !== 1'b1) @(posedge i_clk_sys);
      cyc <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0);
    end
  endtask
  task settle;
    repeat (24) @(posedge i_clk_sys);
  endtask
  task move(input integer n);
    repeat (n) begin
      @(posedge i_clk_sys) step <= 1'b1;
      @(posedge i_clk_sys) step <= 1'b0;
      // long enough for sync, count and output register to settle
      repeat (10) @(posedge i_clk_sys);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ----
  // clock, monitor, timeout
  // ----
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    if (ack === 1'b1 && !we) chk(rdat, exp_q.pop_front());
  end
  always @(posedge i_clk_sys) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    i_resetn = 0; cyc = 0; we = 0; adr = 0; wdat = 0; di = 0; step = 0;
    rev = 0; idx = 0; run = 0; ofreq = 16'h0064; lf = 16'h002E;
    n_errors = 0; n_compared = 0; cyc_cnt = 0;
    repeat (2) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    chk(maxf, 16'h01F4);
    chk(bias, `MPZ_BIAS_NONE);
    rd(`MPZ_A_PPR, 32'h0000_0400);
    rd(8'h44, 32'h0);
    wb(1'b1, `MPZ_A_MAXF, 32'h0);
    rd(`MPZ_A_MAXF, 32'h1);
    wb(1'b1, `MPZ_A_MAXF, 32'h7D0);
    rd(`MPZ_A_MAXF, 32'h3E8);
    wb(1'b1, `MPZ_A_OFS, 32'h4E20);
    rd(`MPZ_A_OFS, 32'h270F);
    wb(1'b1, `MPZ_A_OFS, 32'h64);
    wb(1'b1, `MPZ_A_SEC, 32'h2EE0);
    rd(`MPZ_A_SEC, 32'h270F);
    wb(1'b1, `MPZ_A_SEC + 8'h04, 32'hFFFF_D120);
    rd(`MPZ_A_SEC + 8'h04, 32'hFFFF_D8F1);
    $display("test bus done");
    wb(1'b1, `MPZ_A_DIFN0, `MPZ_FN_HOLD);
    wb(1'b1, 8'h08, `MPZ_FN_SWPOS);
    wb(1'b1, 8'h0C, `MPZ_FN_POSEN);
    for (k = 0; k < 4; k = k + 1)
      wb(1'b1, 8'h10 + 8'h04 * k[7:0], `MPZ_FN_SEL0 + k[7:0]);
    for (k = 0; k < 16; k = k + 1) begin
      lf = lfsr(lf);
      pv = {16'h0, lf} % 9999;
      if (lf[0]) pv = -pv;
      rv = k % 3 - 1;
      tgt[k] = rv * 1024 + pv;
      wb(1'b1, `MPZ_A_SEC + 8'h08 * k[7:0], rv);
      wb(1'b1, `MPZ_A_SEC + 8'h08 * k[7:0] + 8'h04, pv);
    end
    di <= 8'h50;
    settle;
    chk(ssel, 4'hA);
    run <= 1'b1;
    move(5);
    rd(`MPZ_A_POS, 32'h5);
    di <= 8'h51;
    settle;
    chk(pmode, 1'b0);
    ofreq <= 16'h000A;
    settle;
    chk(pmode, 1'b1);
    chk(pref, 32'h0);
    chk(perr, 32'h0);
    di <= 8'h07;
    settle;
    for (k = 15; k >= 0; k = k - 1) begin
      di[6:3] <= k[3:0];
      settle;
      chk(pref, tgt[k]);
      chk({mpos, ssel}, 5'h10);
    end
    di <= 8'h2B;
    settle;
    chk(pref, tgt[0]);
    di[2] <= 1'b1;
    settle;
    chk(pref, tgt[5]);
    move(3);
    chk(perr, tgt[5] - 3);
    chk(ramp, tgt[5] != 3);
    $display("test direct mode done");
    di <= 8'h00;
    settle;
    chk(pmode, 1'b0);
    wb(1'b1, `MPZ_A_CTRL, 32'h1);
    di <= 8'h01;
    settle;
    chk(pmode, 1'b0);
    chk(bias, `MPZ_BIAS_NONE);
    idx <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    idx <= 1'b0;
    settle;
    chk(pmode, 1'b1);
    chk(bias, 32'h0);
    chk(perr, 32'h64);
    move(3);
    chk(bias, 32'h3);
    chk(perr, 32'h61);
    rd(`MPZ_A_BIAS, 32'h3);
    rd(`MPZ_A_ERR, 32'h61);
    // reverse steps must count down
    rev <= 1'b1;
    move(2);
    chk(bias, 32'h1);
    chk(perr, 32'h63);
    run <= 1'b0;
    settle;
    chk(pmode, 1'b0);
    $display("test index mode done");
    tally_and_finish;
  end
endmodule

// File: src/mpz_defs.vh
`ifndef MPZ_DEFS_VH
`define MPZ_DEFS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MPZ_A_CTRL 8'h00
`define MPZ_A_DIFN0 8'h04
`define MPZ_A_DIFN7 8'h20
`define MPZ_A_MAXF 8'h24
`define MPZ_A_PPR 8'h28
`define MPZ_A_OFS 8'h2C
`define MPZ_A_FMIN 8'h30
`define MPZ_A_STAT 8'h34
`define MPZ_A_ERR 8'h38
`define MPZ_A_BIAS 8'h3C
`define MPZ_A_POS 8'h40
`define MPZ_A_SEC 8'h80
// ----------------------------------------
// fields, codes, resets and limits
// ----------------------------------------
`define MPZ_CTRL_MODE 0
`define MPZ_FN_SEL0 8'h02
`define MPZ_FN_SEL1 8'h03
`define MPZ_FN_SEL2 8'h04
`define MPZ_FN_SEL3 8'h05
`define MPZ_FN_HOLD 8'h2E
`define MPZ_FN_SWPOS 8'h33
`define MPZ_FN_POSEN 8'h34
`define MPZ_LIM 16'h270F
`define MPZ_BIAS_NONE 32'h0000270F
`define MPZ_MAXF_MIN 16'h0001
`define MPZ_MAXF_MAX 16'h03E8
`define MPZ_MAXF_RST 16'h01F4
`define MPZ_PPR_RST 16'h0400
`define MPZ_FMIN_RST 16'h000F
`define MPZ_OFS_RST 16'h0000
`define MPZ_FN_RST 8'h00
`endif

// File: src/mpz_sec_mem.v
`timescale 1ns/10ps
module mpz_sec_mem (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_ce,
  input wire [3:0] i_waddr,
  input wire i_we_hi,
  input wire i_we_lo,
  input wire [15:0] i_wdata,
  input wire [3:0] i_raddr_a,
  output reg [31:0] o_rdata_a,
  input wire [3:0] i_raddr_b,
  output reg [31:0] o_rdata_b
);
  // upper half revolutions, lower half pulses
  reg [31:0] mem [0:15];
  integer k;
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (k = 0; k < 16; k = k + 1) begin
        mem[k] <= 32'h00000000;
      end
      o_rdata_a <= 32'h00000000;
      o_rdata_b <= 32'h00000000;
    end else if (i_ce) begin
      if (i_we_hi) begin
        mem[i_waddr][31:16] <= i_wdata;
      end
      if (i_we_lo) begin
        mem[i_waddr][15:0] <= i_wdata;
      end
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end
endmodule

// File: src/mpz_sync.v
`timescale 1ns/10ps
module mpz_sync #(
  parameter W = 1
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_ce,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_level
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer k;
  // first stage feeds only the second
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      o_level <= {W{1'b0}};
    end else if (i_ce) begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (k = 0; k < W; k = k + 1) begin
        if (s2_r[k] == s3_r[k]) begin
          o_level[k] <= s3_r[k];
        end
      end
    end
  end
endmodule

// File: src/mpz_top.v
`timescale 1ns/10ps
`include "mpz_defs.vh"
module mpz_top (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_ce,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire [7:0] i_di,
  input wire i_enc_a,
  input wire i_enc_b,
  input wire i_enc_z,
  input wire i_run,
  input wire [15:0] i_out_freq,
  output reg o_pos_mode,
  output reg o_multi_pos,
  output reg o_ramp_set1,
  output reg [15:0] o_max_freq,
  output reg [3:0] o_speed_sel,
  output reg [31:0] o_position_reference,
  output reg [31:0] o_pos_err,
  output reg [31:0] o_index_bias
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_SPEED = 3'b001;
  localparam [2:0] ST_WAITZ = 3'b010;
  localparam [2:0] ST_HOLD = 3'b100;

  reg [2:0] state_r;
  reg mode_r;
  reg [7:0] difn_r [0:7];
  reg [15:0] ppr_r;
  reg [15:0] ofs_r;
  reg [15:0] fmin_r;
  reg pend_r;
  reg [31:0] pos_cnt_r;
  reg [31:0] idx_pos_r;
  reg idx_seen_r;
  reg [31:0] origin_r;
  reg [3:0] sel_r;
  reg sec_valid_r;
  reg [31:0] target_r;
  reg [1:0] ab_prev_r;
  reg z_prev_r;
  wire [7:0] di_f;
  wire [2:0] enc_f;
  wire [31:0] mem_a;
  wire [31:0] mem_b;
  integer t;
  // separate loop index keeps t out of the clocked process
  integer ri;

  // ----------------------------------------
  // input conditioning
  // ----------------------------------------
  mpz_sync #(.W(8)) u_di_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_async(i_di),
    .o_level(di_f)
  );

  mpz_sync #(.W(3)) u_enc_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_async({i_enc_z, i_enc_b, i_enc_a}),
    .o_level(enc_f)
  );

  // ----------------------------------------
  // terminal function decode
  // ----------------------------------------
  reg [3:0] sel_bits;
  reg fn_hold;
  reg fn_swpos;
  reg fn_posen;
  always @* begin
    sel_bits = 4'h0;
    fn_hold = 1'b0;
    fn_swpos = 1'b0;
    fn_posen = 1'b0;
    for (t = 0; t < 8; t = t + 1) begin
      if (di_f[t]) begin
        if (difn_r[t] == `MPZ_FN_SEL0) sel_bits[0] = 1'b1;
        if (difn_r[t] == `MPZ_FN_SEL1) sel_bits[1] = 1'b1;
        if (difn_r[t] == `MPZ_FN_SEL2) sel_bits[2] = 1'b1;
        if (difn_r[t] == `MPZ_FN_SEL3) sel_bits[3] = 1'b1;
        if (difn_r[t] == `MPZ_FN_HOLD) fn_hold = 1'b1;
        if (difn_r[t] == `MPZ_FN_SWPOS) fn_swpos = 1'b1;
        if (difn_r[t] == `MPZ_FN_POSEN) fn_posen = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // encoder decode
  // ----------------------------------------
  wire step = (enc_f[0] ^ ab_prev_r[0]) ^ (enc_f[1] ^ ab_prev_r[1]);
  wire up = enc_f[0] ^ ab_prev_r[1];
  wire z_rise = enc_f[2] & ~z_prev_r;
  wire below = (i_out_freq < fmin_r);
  wire [31:0] ofs_ext = {16'h0000, ofs_r};

  // ----------------------------------------
  // bus access
  // ----------------------------------------
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wb_wr = pend_r & i_wb_we & (i_wb_sel == 4'hF);
  wire sec_hit = (i_wb_adr >= `MPZ_A_SEC);
  wire sec_half = i_wb_adr[2];

  // clamp signed setting into +-9999
  function [15:0] clamp_lim;
    input [31:0] v;
    begin
      if ($signed(v) > $signed({16'h0000, `MPZ_LIM})) begin
        clamp_lim = `MPZ_LIM;
      end else if ($signed(v) < -$signed({16'h0000, `MPZ_LIM})) begin
        clamp_lim = 16'h0000 - `MPZ_LIM;
      end else begin
        clamp_lim = v[15:0];
      end
    end
  endfunction

  wire [15:0] sec_wdata = clamp_lim(i_wb_dat);

  mpz_sec_mem u_sec_mem (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_waddr(i_wb_adr[6:3]),
    .i_we_hi(wb_wr & sec_hit & ~sec_half),
    .i_we_lo(wb_wr & sec_hit & sec_half),
    .i_wdata(sec_wdata),
    .i_raddr_a(i_wb_adr[6:3]),
    .o_rdata_a(mem_a),
    .i_raddr_b(sel_r),
    .o_rdata_b(mem_b)
  );

  // ----------------------------------------
  // target and error arithmetic
  // ----------------------------------------
  // signed settings, positive means forward
  wire signed [16:0] ppr_s = {1'b0, ppr_r};
  wire signed [15:0] rev_s = mem_b[31:16];
  wire signed [32:0] rev_prod = rev_s * ppr_s;
  wire [31:0] pul_ext = {{16{mem_b[15]}}, mem_b[15:0]};
  wire [31:0] target_nxt = rev_prod[31:0] + pul_ext;
  wire use_sec = (state_r == ST_HOLD) & fn_swpos & sec_valid_r;
  // absolute: target measured from origin
  wire [31:0] ref_nxt = use_sec ? target_r : 32'h00000000;
  wire [31:0] rel_pos = pos_cnt_r - origin_r;
  wire [31:0] bias_nxt = idx_seen_r ? (pos_cnt_r - idx_pos_r) :
    `MPZ_BIAS_NONE;

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (sec_hit) begin
      rd_mux = sec_half ? {{16{mem_a[15]}}, mem_a[15:0]} :
        {{16{mem_a[31]}}, mem_a[31:16]};
    end else if (i_wb_adr == `MPZ_A_CTRL) begin
      rd_mux = {31'h00000000, mode_r};
    end else if (i_wb_adr >= `MPZ_A_DIFN0 && i_wb_adr <= `MPZ_A_DIFN7) begin
      rd_mux = {24'h000000, difn_r[i_wb_adr[4:2] - 3'h1]};
    end else if (i_wb_adr == `MPZ_A_MAXF) begin
      rd_mux = {16'h0000, o_max_freq};
    end else if (i_wb_adr == `MPZ_A_PPR) begin
      rd_mux = {16'h0000, ppr_r};
    end else if (i_wb_adr == `MPZ_A_OFS) begin
      rd_mux = {16'h0000, ofs_r};
    end else if (i_wb_adr == `MPZ_A_FMIN) begin
      rd_mux = {16'h0000, fmin_r};
    end else if (i_wb_adr == `MPZ_A_STAT) begin
      rd_mux = {23'h000000, sec_valid_r, sel_r, idx_seen_r, state_r};
    end else if (i_wb_adr == `MPZ_A_ERR) begin
      rd_mux = o_pos_err;
    end else if (i_wb_adr == `MPZ_A_BIAS) begin
      rd_mux = o_index_bias;
    end else if (i_wb_adr == `MPZ_A_POS) begin
      rd_mux = pos_cnt_r;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_r <= 1'b0;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      mode_r <= 1'b0;
      o_max_freq <= `MPZ_MAXF_RST;
      ppr_r <= `MPZ_PPR_RST;
      ofs_r <= `MPZ_OFS_RST;
      fmin_r <= `MPZ_FMIN_RST;
      for (ri = 0; ri < 8; ri = ri + 1) begin
        difn_r[ri] <= `MPZ_FN_RST;
      end
    end else if (i_ce) begin
      // extra cycle lets section memory read settle
      pend_r <= wb_req & ~pend_r;
      o_wb_ack <= pend_r;
      if (pend_r) begin
        o_wb_dat <= rd_mux;
      end
      if (wb_wr && !sec_hit) begin
        if (i_wb_adr == `MPZ_A_CTRL) begin
          mode_r <= i_wb_dat[`MPZ_CTRL_MODE];
        end else if (i_wb_adr >= `MPZ_A_DIFN0 &&
                     i_wb_adr <= `MPZ_A_DIFN7) begin
          difn_r[i_wb_adr[4:2] - 3'h1] <= i_wb_dat[7:0];
        end else if (i_wb_adr == `MPZ_A_MAXF) begin
          if (i_wb_dat[15:0] < `MPZ_MAXF_MIN) begin
            o_max_freq <= `MPZ_MAXF_MIN;
          end else if (i_wb_dat[15:0] > `MPZ_MAXF_MAX ||
                       i_wb_dat[31:16] != 16'h0000) begin
            o_max_freq <= `MPZ_MAXF_MAX;
          end else begin
            o_max_freq <= i_wb_dat[15:0];
          end
        end else if (i_wb_adr == `MPZ_A_PPR) begin
          ppr_r <= i_wb_dat[15:0];
        end else if (i_wb_adr == `MPZ_A_OFS) begin
          if (i_wb_dat[15:0] > `MPZ_LIM || i_wb_dat[31:16] != 16'h0000) begin
            ofs_r <= `MPZ_LIM;
          end else begin
            ofs_r <= i_wb_dat[15:0];
          end
        end else if (i_wb_adr == `MPZ_A_FMIN) begin
          fmin_r <= i_wb_dat[15:0];
        end
      end
    end
  end

  // ----------------------------------------
  // position accumulator and index capture
  // ----------------------------------------
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ab_prev_r <= 2'b00;
      z_prev_r <= 1'b0;
      pos_cnt_r <= 32'h00000000;
      idx_pos_r <= 32'h00000000;
      idx_seen_r <= 1'b0;
    end else if (i_ce) begin
      ab_prev_r <= enc_f[1:0];
      z_prev_r <= enc_f[2];
      if (step) begin
        pos_cnt_r <= up ? pos_cnt_r + 32'h00000001 :
          pos_cnt_r - 32'h00000001;
      end
      if (z_rise) begin
        idx_pos_r <= pos_cnt_r;
        idx_seen_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // positioning state machine
  // ----------------------------------------
  // hold leaves only when run or hold command drops
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_SPEED;
      origin_r <= 32'h00000000;
      sel_r <= 4'h0;
      sec_valid_r <= 1'b0;
      target_r <= 32'h00000000;
    end else if (i_ce) begin
      target_r <= target_nxt;
      case (state_r)
        ST_SPEED: begin
          sec_valid_r <= 1'b0;
          if (i_run && fn_hold && below) begin
            if (!mode_r) begin
              origin_r <= pos_cnt_r;
              state_r <= ST_HOLD;
            end else begin
              state_r <= ST_WAITZ;
            end
          end
        end
        ST_WAITZ: begin
          if (!i_run || !fn_hold) begin
            state_r <= ST_SPEED;
          end else if (z_rise) begin
            origin_r <= pos_cnt_r + ofs_ext;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!i_run || !fn_hold) begin
            state_r <= ST_SPEED;
            sec_valid_r <= 1'b0;
          end else if (fn_swpos && fn_posen) begin
            // code k picks section k, so no select inputs picks section 0; origin until a section is taken
            sel_r <= sel_bits;
            sec_valid_r <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_SPEED;
        end
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // target lags a new select by two cycles of memory and math
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pos_mode <= 1'b0;
      o_multi_pos <= 1'b0;
      o_ramp_set1 <= 1'b0;
      o_speed_sel <= 4'h0;
      o_position_reference <= 32'h00000000;
      o_pos_err <= 32'h00000000;
      o_index_bias <= `MPZ_BIAS_NONE;
    end else if (i_ce) begin
      o_pos_mode <= (state_r == ST_HOLD);
      o_multi_pos <= (state_r == ST_HOLD) & fn_swpos;
      o_speed_sel <= ((state_r == ST_HOLD) & fn_swpos) ? 4'h0 :
        sel_bits;
      o_ramp_set1 <= (state_r == ST_HOLD) &
        (o_pos_err != 32'h00000000);
      o_position_reference <= ref_nxt;
      o_pos_err <= ref_nxt - rel_pos;
      o_index_bias <= bias_nxt;
    end
  end
endmodule
